//--- rtl/sspi_pkg.sv
// Constants and types shared by the synchronous serial port files
package sspi_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int REG_W = 8;
  localparam int ADDR_W = 3;
  localparam int DIV_W_MIN = 7;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL_A = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_CTRL_B = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_INT_CTRL = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_INT_FLAGS = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_DATA = 3'h4;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CA_ENABLE = 0;
  localparam int CA_CLOCK_PRESCALER_LO = 1;
  localparam int CA_CLOCK_PRESCALER_HI = 2;
  localparam int CA_DOUBLE = 4;
  localparam int CA_HOST = 5;
  localparam int CA_ORDER = 6;
  localparam int CB_CPHA = 0;
  localparam int CB_CPOL = 1;
  localparam int CB_SSD = 2;
  localparam int CB_BUFFER_WAIT_RECEIVE = 6;
  localparam int CB_BUFFER_MODE_ENABLE = 7;
  localparam int FL_DRE = 4;
  localparam int FL_TXC = 5;
  localparam int FL_WCOL = 6;
  localparam int FL_IF = 7;

  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic [REG_W-1:0] RST_CTRL_A = 8'h00;
  localparam logic [REG_W-1:0] RST_CTRL_B = 8'h00;
  localparam logic [REG_W-1:0] RST_INT_CTRL = 8'h00;
  localparam logic [REG_W-1:0] MASK_CTRL_A = 8'h77;
  localparam logic [REG_W-1:0] MASK_CTRL_B = 8'hc7;
  localparam logic [REG_W-1:0] MASK_INT = 8'hf0;

  // ----------------------------------------------------------------
  // Serial clock half periods in peripheral clocks, and the last edge count of a word
  // ----------------------------------------------------------------
  localparam logic [6:0] HALF_DIV4 = 7'h02;
  localparam logic [6:0] HALF_DIV16 = 7'h08;
  localparam logic [6:0] HALF_DIV64 = 7'h20;
  localparam logic [6:0] HALF_DIV128 = 7'h40;
  localparam logic [6:0] HALF_DIV2 = 7'h01;
  localparam logic [6:0] HALF_DIV8 = 7'h04;
  localparam logic [6:0] HALF_DIV32 = 7'h10;
  localparam logic [3:0] EDGE_LAST = 4'hf;

  // ----------------------------------------------------------------
  // Transfer states
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {ST_IDLE, ST_SHIFT} xfer_state_t;

endpackage

//--- rtl/sck_if.sv
// Interface between the port core and its serial clock unit
`timescale 1ns/1ps
`default_nettype none
interface sck_if;
  logic host_run;
  logic clk_double;
  logic [1:0] prescaler;
  logic sck_pin;
  logic tick;
  logic client_edge;
  modport core (output host_run, clk_double, prescaler, sck_pin, input tick, client_edge);
  modport gen (input host_run, clk_double, prescaler, sck_pin, output tick, client_edge);
endinterface
`default_nettype wire

//--- rtl/sck_unit.sv
// Serial clock unit: host rate divider and client clock synchroniser
`timescale 1ns/1ps
`default_nettype none
module sck_unit
  import sspi_pkg::*;
#(
  parameter int DIV_W = 7
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link to the port core
  sck_if.gen sck
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (DIV_W < DIV_W_MIN) begin : g_bad_div
    $error("DIV_W too small for the slowest rate");
  end

  // Half period chosen by prescaler and double-speed bit
  function automatic logic [DIV_W-1:0] half_count(input logic [1:0] clock_prescaler, input logic dbl);
    logic [6:0] h;
    h = HALF_DIV4;
    case ({dbl, clock_prescaler})
      3'h0: h = HALF_DIV4;
      3'h1: h = HALF_DIV16;
      3'h2: h = HALF_DIV64;
      3'h3: h = HALF_DIV128;
      3'h4: h = HALF_DIV2;
      3'h5: h = HALF_DIV8;
      3'h6: h = HALF_DIV32;
      3'h7: h = HALF_DIV64;
      default: h = HALF_DIV4;
    endcase
    half_count = DIV_W'(h);
  endfunction

  logic [DIV_W-1:0] div_cnt_ff;
  logic [DIV_W-1:0] half_last;
  logic meta_ff;
  logic sync_ff;
  logic prev_ff;

  assign half_last = half_count(sck.prescaler, sck.clk_double) - DIV_W'(1);

  // Divider restarts with each run so the first half period is whole
  always_ff @(posedge clk) begin
    if (rst || !sck.host_run) begin
      div_cnt_ff <= '0;
    end else if (div_cnt_ff == half_last) begin
      div_cnt_ff <= '0;
    end else begin
      div_cnt_ff <= div_cnt_ff + DIV_W'(1);
    end
  end

  assign sck.tick = sck.host_run && (div_cnt_ff == half_last);

  // Two-stage synchroniser, edge taken after the second stage
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      meta_ff <= sck.sck_pin;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign sck.client_edge = sync_ff ^ prev_ff;

endmodule
`default_nettype wire

//--- rtl/sspi_port.sv
// Synchronous serial port, host or client, with register access
//
// Function
// - One 8-bit shift register exchanges one bit out and in per serial clock period.
// - Data writes load shift register normally, transmit buffer in buffer mode unless the host is idle.
// - Data reads return receive register normally, receive queue in buffer mode.
// - Host makes its serial clock; client synchronises and samples incoming clock.
// - Only the host starts transfers; client follows clock and select.
// - Host-to-client data on MOSI, client-to-host data on MISO.
// - Enabled port forces MISO input as host; MOSI, SCK, SS as client.
// - Pins set as outputs take their level from the port logic.
// - Client drives MISO while select is low and its direction is output, releases it when high.
// - A host data write while idle starts a new transfer.
// - Host normal mode: one-word transmit, two-word receive path.
// - Bit order selectable, same for both directions.
// - Prescaler and double bit give seven rates, fastest clock over two.
// - Select-disable set in host role ignores the select pin.
// - Mode field sets polarity and phase; buffer bits separate.
// - End-of-transfer flag and write-collision flag readable.
// - Host normal busy write corrupts data, sets collision; completion sets flag.
// - Host buffer mode receives into two-entry queue; overflow loses data.
// - Low select input drops host role and sets the transfer flag.
`timescale 1ns/1ps
`default_nettype none
module sspi_port
  import sspi_pkg::*;
#(
  parameter int DIV_W = 7
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [REG_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [REG_W-1:0] rdata,
  // Pin directions from the port, high for output
  input wire logic mosi_dir,
  input wire logic miso_dir,
  input wire logic sck_dir,
  input wire logic ss_dir,
  // Serial pins
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe_n,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe_n,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe_n,
  input wire logic ss_in,
  output logic ss_out,
  output logic ss_oe_n,
  // Interrupt request
  output logic irq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic [REG_W-1:0] shift_in(input logic [REG_W-1:0] sh, input logic b, input logic lsb);
    shift_in = lsb ? {b, sh[REG_W-1:1]} : {sh[REG_W-2:0], b};
  endfunction

  function automatic logic out_bit(input logic [REG_W-1:0] sh, input logic lsb);
    out_bit = lsb ? sh[0] : sh[REG_W-1];
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [REG_W-1:0] ctrl_a_ff;
  logic [REG_W-1:0] ctrl_b_ff;
  logic [REG_W-1:0] int_ctrl_ff;
  logic [REG_W-1:0] flags_ff;
  logic [REG_W-1:0] flags_view;
  logic [REG_W-1:0] shreg_ff;
  logic [REG_W-1:0] nxt_shreg;
  logic [REG_W-1:0] shifted;
  logic [REG_W-1:0] rx_word;
  logic [REG_W-1:0] txbuf_ff;
  logic txbuf_valid_ff;
  logic [REG_W-1:0] rxdata_ff;
  logic [REG_W-1:0] rxq_ff [0:1];
  logic rxq_wp_ff;
  logic rxq_rp_ff;
  logic [1:0] rxq_cnt_ff;
  logic [REG_W-1:0] rdata_ff;
  logic [3:0] edge_ff;
  logic sck_ff;
  logic dout_ff;
  xfer_state_t state_ff;
  xfer_state_t nxt_state;
  logic en, host, lsb_first, cpol, cpha, buffer_mode_enable, select_disable;
  logic busy, mid, lead, ev, sample_ev, out_ev, done;
  logic wr_data, rd_data, takeover, client_active, in_bit;
  logic load_wdata, load_buf, buf_write, wcol_set, push, pop;

  sck_if sck ();

  sck_unit #(.DIV_W(DIV_W)) u_sck (
    .clk(clk),
    .rst(rst),
    .sck(sck.gen)
  );

  if (DIV_W < DIV_W_MIN) begin : g_bad_div
    $error("DIV_W too small for the slowest rate");
  end

  // ----------------------------------------------------------------
  // Control decode
  // ----------------------------------------------------------------
  assign en = ctrl_a_ff[CA_ENABLE];
  assign host = ctrl_a_ff[CA_HOST];
  assign lsb_first = ctrl_a_ff[CA_ORDER];
  assign cpol = ctrl_b_ff[CB_CPOL];
  assign cpha = ctrl_b_ff[CB_CPHA];
  assign buffer_mode_enable = ctrl_b_ff[CB_BUFFER_MODE_ENABLE];
  assign select_disable = ctrl_b_ff[CB_SSD];
  assign wr_data = wr && hit(addr, OFS_DATA);
  assign rd_data = rd && hit(addr, OFS_DATA);
  assign busy = (state_ff == ST_SHIFT);
  // Client counts as mid-word once the first edge has arrived
  assign mid = busy && (host || (edge_ff != 4'h0));

  // Another host pulling select low takes the bus from us
  assign takeover = en && host && !select_disable && !ss_dir && !ss_in;
  assign client_active = en && !host && !ss_in;

  // ----------------------------------------------------------------
  // Clock unit link
  // ----------------------------------------------------------------
  assign sck.host_run = busy && host;
  assign sck.clk_double = ctrl_a_ff[CA_DOUBLE];
  assign sck.prescaler = ctrl_a_ff[CA_CLOCK_PRESCALER_HI:CA_CLOCK_PRESCALER_LO];
  assign sck.sck_pin = sck_in;

  // ----------------------------------------------------------------
  // Edge events
  // ----------------------------------------------------------------
  // Even edge counts are leading edges, odd ones trailing
  assign lead = !edge_ff[0];
  assign ev = busy && (host ? sck.tick : (sck.client_edge && client_active));
  assign sample_ev = ev && (lead ^ cpha);
  assign out_ev = ev && !(lead ^ cpha);
  assign done = ev && (edge_ff == EDGE_LAST);
  assign in_bit = host ? miso_in : mosi_in;
  assign shifted = shift_in(shreg_ff, in_bit, lsb_first);
  assign rx_word = sample_ev ? shifted : shreg_ff;

  // ----------------------------------------------------------------
  // Data write steering
  // ----------------------------------------------------------------
  // Host normal write while busy still lands, corrupting the word
  assign load_wdata = wr_data && en && (host ? (!buffer_mode_enable || !busy) : (!buffer_mode_enable && !mid));
  assign load_buf = buffer_mode_enable && txbuf_valid_ff && (done || (!host && !mid && !load_wdata));
  assign buf_write = wr_data && en && buffer_mode_enable && !load_wdata && !txbuf_valid_ff;
  assign wcol_set = wr_data && en && ((!buffer_mode_enable && mid) || (buffer_mode_enable && !load_wdata && txbuf_valid_ff));

  // ----------------------------------------------------------------
  // Shift register next value
  // ----------------------------------------------------------------
  always_comb begin
    nxt_shreg = shreg_ff;
    if (load_wdata) begin
      nxt_shreg = wdata;
    end else if (load_buf) begin
      nxt_shreg = txbuf_ff;
    end else if (sample_ev) begin
      nxt_shreg = shifted;
    end
  end

  // Shift register
  always_ff @(posedge clk) begin
    if (rst) begin
      shreg_ff <= '0;
    end else begin
      shreg_ff <= nxt_shreg;
    end
  end

  // Output bit follows the word when idle and moves on out edges
  always_ff @(posedge clk) begin
    if (rst) begin
      dout_ff <= 1'b0;
    end else if (!busy || out_ev || load_wdata || load_buf) begin
      dout_ff <= out_bit(nxt_shreg, lsb_first);
    end
  end

  // ----------------------------------------------------------------
  // Transfer state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (load_wdata && host && !takeover) begin
          nxt_state = ST_SHIFT;
        end else if (client_active) begin
          nxt_state = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (!en || takeover) begin
          nxt_state = ST_IDLE;
        end else if (host && done && !load_buf) begin
          nxt_state = ST_IDLE;
        end else if (!host && !client_active) begin
          nxt_state = ST_IDLE; // partial word is dropped
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Edge counter wraps to zero after the last edge of a word
  always_ff @(posedge clk) begin
    if (rst || !busy) begin
      edge_ff <= 4'h0;
    end else if (ev) begin
      edge_ff <= edge_ff + 4'h1;
    end
  end

  // Host serial clock rests at the idle level between words
  always_ff @(posedge clk) begin
    if (rst || !(busy && host)) begin
      sck_ff <= cpol;
    end else if (sck.tick) begin
      sck_ff <= !sck_ff;
    end
  end

  // ----------------------------------------------------------------
  // Transmit buffer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      txbuf_ff <= '0;
      txbuf_valid_ff <= 1'b0;
    end else if (buf_write) begin
      txbuf_ff <= wdata;
      txbuf_valid_ff <= 1'b1;
    end else if (load_buf || !buffer_mode_enable) begin
      txbuf_valid_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Receive paths
  // ----------------------------------------------------------------
  // Normal mode: shift register plus one holding register
  always_ff @(posedge clk) begin
    if (rst) begin
      rxdata_ff <= '0;
    end else if (done && !buffer_mode_enable) begin
      rxdata_ff <= rx_word;
    end
  end

  // Two-entry queue; a word arriving when full is lost
  assign push = done && buffer_mode_enable && (rxq_cnt_ff != 2'h2);
  assign pop = rd_data && buffer_mode_enable && (rxq_cnt_ff != 2'h0);

  always_ff @(posedge clk) begin
    if (rst) begin
      rxq_wp_ff <= 1'b0;
    end else if (push) begin
      rxq_ff[rxq_wp_ff] <= rx_word;
      rxq_wp_ff <= !rxq_wp_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rxq_rp_ff <= 1'b0;
      rxq_cnt_ff <= 2'h0;
    end else begin
      if (pop) begin
        rxq_rp_ff <= !rxq_rp_ff;
      end
      rxq_cnt_ff <= rxq_cnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Takeover beats a software write in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_a_ff <= RST_CTRL_A;
    end else if (takeover) begin
      ctrl_a_ff[CA_HOST] <= 1'b0;
    end else if (wr && hit(addr, OFS_CTRL_A)) begin
      ctrl_a_ff <= wdata & MASK_CTRL_A;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_b_ff <= RST_CTRL_B;
      int_ctrl_ff <= RST_INT_CTRL;
    end else begin
      if (wr && hit(addr, OFS_CTRL_B)) begin
        ctrl_b_ff <= wdata & MASK_CTRL_B;
      end
      if (wr && hit(addr, OFS_INT_CTRL)) begin
        int_ctrl_ff <= wdata & MASK_INT;
      end
    end
  end

  // ----------------------------------------------------------------
  // Flags, write one to clear, setting wins
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      flags_ff <= '0;
    end else begin
      if (wr && hit(addr, OFS_INT_FLAGS)) begin
        flags_ff <= flags_ff & ~wdata;
      end
      if ((done && !buffer_mode_enable) || takeover) begin
        flags_ff[FL_IF] <= 1'b1;
      end
      if (wcol_set) begin
        flags_ff[FL_WCOL] <= 1'b1;
      end
      if (done && buffer_mode_enable && !txbuf_valid_ff) begin
        flags_ff[FL_TXC] <= 1'b1;
      end
      flags_ff[FL_DRE] <= 1'b0;
    end
  end

  // Buffer-empty is a live status, not a sticky bit
  assign flags_view = {flags_ff[REG_W-1:FL_DRE+1], buffer_mode_enable && !txbuf_valid_ff, flags_ff[FL_DRE-1:0]};
  assign irq = |(flags_view & int_ctrl_ff);

  // ----------------------------------------------------------------
  // Read data, valid only in the cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst || !rd) begin
      rdata_ff <= '0;
    end else begin
      case (addr)
        OFS_CTRL_A: rdata_ff <= ctrl_a_ff;
        OFS_CTRL_B: rdata_ff <= ctrl_b_ff;
        OFS_INT_CTRL: rdata_ff <= int_ctrl_ff;
        OFS_INT_FLAGS: rdata_ff <= flags_view;
        OFS_DATA: rdata_ff <= buffer_mode_enable ? rxq_ff[rxq_rp_ff] : rxdata_ff;
        default: rdata_ff <= '0;
      endcase
    end
  end

  assign rdata = rdata_ff;

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  // Outputs only where the port direction says output and role allows
  assign sck_out = sck_ff;
  assign sck_oe_n = !(en && host && sck_dir);
  assign mosi_out = dout_ff;
  assign mosi_oe_n = !(en && host && mosi_dir);
  assign miso_out = dout_ff;
  assign miso_oe_n = !(en && !host && miso_dir && !ss_in);
  // Own select output goes low for the length of a host word
  assign ss_out = !(busy && host);
  assign ss_oe_n = !(en && host && ss_dir);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_host_write_start: assert property (
    (en && host && !busy && wr_data && !takeover) |=> busy ##0 (shreg_ff == $past(wdata)))
    else $error("host write did not start a transfer");

  a_busy_write_wcol: assert property (
    (wr_data && en && !buffer_mode_enable && host && busy) |=> flags_ff[FL_WCOL])
    else $error("busy write did not flag a collision");

  a_client_miso_off: assert property (
    (!host && ss_in) |-> miso_oe_n)
    else $error("client drove MISO while unselected");

  a_host_miso_in: assert property (
    (en && host) |-> miso_oe_n)
    else $error("host drove MISO");

  a_takeover_client: assert property (
    takeover |=> (!host && flags_ff[FL_IF] && !busy))
    else $error("select low did not hand over the bus");

  a_done_sets_if: assert property (
    (done && !buffer_mode_enable && !(wr && hit(addr, OFS_INT_FLAGS))) |=> flags_ff[FL_IF] && rxdata_ff == $past(rx_word))
    else $error("completed word not flagged or stored");

  a_fast_rate: assert property (
    (busy && host && $past(busy) && ctrl_a_ff[CA_DOUBLE] && ctrl_a_ff[CA_CLOCK_PRESCALER_HI:CA_CLOCK_PRESCALER_LO] == 2'h0)
      |-> (sck_ff != $past(sck_ff)))
    else $error("fastest rate is not half the clock");

  a_buf_write: assert property (
    buf_write |=> (txbuf_valid_ff && txbuf_ff == $past(wdata)))
    else $error("buffer write lost");

  a_read_data: assert property (
    (rd_data && !buffer_mode_enable) |=> (rdata == $past(rxdata_ff)) ##1 (rdata == 8'h00 || $past(rd)))
    else $error("normal read returned wrong data");

endmodule
`default_nettype wire

//--- test/spi_client_model.sv
// Behavioural client at the far end of the serial link, mode 0
`timescale 1ns/1ps
`default_nettype none
module spi_client_model (
  // Serial pins
  input wire logic sck,
  input wire logic ss_n,
  input wire logic mosi,
  output logic miso,
  // Word control
  input wire logic lsb_first,
  input wire logic [7:0] tx_word,
  output logic [7:0] rx_word
);
  logic [7:0] sh_ff;
  initial miso = 1'b0;
  // Load on select so the first bit stands before the first edge
  always @(negedge ss_n) begin
    sh_ff = tx_word;
    miso = lsb_first ? sh_ff[0] : sh_ff[7];
  end
  // Host data taken from MOSI on the leading edge, same order both ways
  always @(posedge sck) begin
    if (!ss_n) rx_word = lsb_first ? {mosi, rx_word[7:1]} : {rx_word[6:0], mosi};
  end
  // Next bit out on the trailing edge, shift in place of a copy
  always @(negedge sck) begin
    if (!ss_n) begin
      sh_ff = lsb_first ? (sh_ff >> 1) : (sh_ff << 1);
      miso = lsb_first ? sh_ff[0] : sh_ff[7];
    end
  end
  // Released line shows the inverse, never the stale bit
  always @(posedge ss_n) miso = ~miso;
endmodule
`default_nettype wire

//--- test/tb_sspi_port.sv
// Self-checking bench for the synchronous serial port
`timescale 1ns/1ps
`default_nettype none
module tb_sspi_port;
  import sspi_pkg::*;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [REG_W-1:0] wdata = '0, rdata, rv, m_tx = '0;
  logic [7:0] m_rx;
  logic mosi_dir = 1'b1, miso_dir = 1'b0, sck_dir = 1'b1, ss_dir = 1'b1, ss_tb = 1'b1, m_lsb = 1'b0;
  logic mosi_out, mosi_oe_n, miso_out, miso_oe_n, sck_out, sck_oe_n, ss_out, ss_oe_n, irq, m_miso;
  int num_errors = 0, num_checks = 0, cyc = 0;
  always #2.5 clk = ~clk;
  // Pin levels seen by the port: select looped back unless the bench owns it
  sspi_port i_sspi_port (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .mosi_dir(mosi_dir), .miso_dir(miso_dir), .sck_dir(sck_dir), .ss_dir(ss_dir),
    .mosi_in(mosi_out), .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n),
    .miso_in(miso_oe_n ? m_miso : miso_out), .miso_out(miso_out), .miso_oe_n(miso_oe_n),
    .sck_in(sck_out), .sck_out(sck_out), .sck_oe_n(sck_oe_n), .ss_in(ss_dir ? ss_out : ss_tb),
    .ss_out(ss_out), .ss_oe_n(ss_oe_n), .irq(irq));
  spi_client_model i_spi_client_model (.sck(sck_out), .ss_n(ss_out), .mosi(mosi_out), .miso(m_miso),
    .lsb_first(m_lsb), .tx_word(m_tx), .rx_word(m_rx));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
      num_errors++;
    end
  endtask
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask
  // Bounded poll of a flag bit
  task automatic wait_flag(input int b);
    for (int i = 0; i < 40; i++) begin
      rd_reg(OFS_INT_FLAGS);
      if (rv[b] === 1'b1) break;
    end
  endtask
  // Control registers come up cleared; an unmapped place reads zero
  task automatic t_reset;
    for (int a = 0; a < 4; a++) begin
      rd_reg(3'(a));
      chk(rv, 8'h00, "reset value");
    end
    wr_reg(3'h7, 8'hff);
    rd_reg(3'h7);
    chk(rv, 8'h00, "unmapped read");
  endtask
  // One host word at the fastest rate, exchanged both ways
  task automatic t_xfer(input logic lsb, input logic [7:0] tx, input logic [7:0] peer);
    m_lsb = lsb;
    m_tx = peer;
    wr_reg(OFS_CTRL_A, {1'b0, lsb, 6'h30});
    wr_reg(OFS_CTRL_A, {1'b0, lsb, 6'h31});
    wr_reg(OFS_DATA, tx);
    wait_flag(FL_IF);
    chk(rv[7:4], 4'h8, "completion flag");
    rd_reg(OFS_DATA);
    chk(rv, peer, "word from MISO");
    chk(m_rx, tx, "word on MOSI");
    wr_reg(OFS_INT_FLAGS, 8'hc0);
    rd_reg(OFS_INT_FLAGS);
    chk(rv, 8'h00, "flags cleared");
  endtask
  // Write during a host word; MISO stays an input as host
  task automatic t_collide;
    miso_dir <= 1'b1;
    wr_reg(OFS_DATA, 8'h3c);
    chk(miso_oe_n, 1'b1, "host miso input");
    wr_reg(OFS_DATA, 8'h5a);
    chk(ss_out, 1'b0, "select low in word");
    wait_flag(FL_IF);
    chk(rv[FL_WCOL], 1'b1, "collision flag");
    miso_dir <= 1'b0;
    wr_reg(OFS_INT_FLAGS, 8'hc0);
  endtask
  // Buffer mode: queued word follows with no gap; peer has nothing left and shifts zeros
  task automatic t_buffer;
    m_tx = 8'ha5;
    wr_reg(OFS_CTRL_B, 8'h80);
    wr_reg(OFS_DATA, 8'h3e);
    wr_reg(OFS_DATA, 8'hd2);
    wait_flag(FL_TXC);
    chk(rv[7:4], 4'h3, "buffer flags");
    rd_reg(OFS_DATA);
    chk(rv, 8'ha5, "first queued word");
    rd_reg(OFS_DATA);
    chk(rv, 8'h00, "second queued word");
    chk(m_rx, 8'hd2, "buffered word on MOSI");
    wr_reg(OFS_CTRL_B, 8'h02);
    @(posedge clk);
    #1 chk(sck_out, 1'b1, "idle clock level");
    wr_reg(OFS_CTRL_B, 8'h00);
    wr_reg(OFS_INT_FLAGS, 8'he0);
  endtask
  // Low select input takes host role away, then MISO follows select
  task automatic t_takeover;
    ss_dir <= 1'b0;
    ss_tb <= 1'b0;
    repeat (3) @(posedge clk);
    rd_reg(OFS_CTRL_A);
    chk(rv, 8'h51, "host bit cleared");
    rd_reg(OFS_INT_FLAGS);
    chk(rv[FL_IF], 1'b1, "takeover flag");
    chk(irq, 1'b0, "request masked");
    wr_reg(OFS_INT_CTRL, 8'h80);
    #1 chk(irq, 1'b1, "request enabled");
    miso_dir <= 1'b1;
    @(posedge clk);
    #1 chk({mosi_oe_n, sck_oe_n, ss_oe_n}, 3'h7, "client inputs");
    chk(miso_oe_n, 1'b0, "client drives miso");
    ss_tb <= 1'b1;
    @(posedge clk);
    #1 chk(miso_oe_n, 1'b1, "client releases miso");
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Hang guard well beyond the 160 or so cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      test_done();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_xfer(1'b0, 8'hc5, 8'h96);
    t_xfer(1'b1, 8'h2b, 8'h71);
    t_collide();
    t_buffer();
    t_takeover();
    test_done();
  end
endmodule
`default_nettype wire
